// file: nps_pkg.sv
// Shared constants and types of the page program sequencer
package nps_pkg;
  // ==========
  // Register offsets and fields
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_CONTROLLER_CONTROL_A = 8'h04;
  localparam logic [7:0] OFS_ADDR = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_LOCK = 8'h14;
  localparam int EXEC_BIT = 0;
  localparam int BUSY_BIT = 0;
  localparam int ABORT_BIT = 1;
  localparam int DENY_BIT = 2;
  // ==========
  // Reset values and widths
  localparam int PTR_W = 16;
  localparam logic [6:0] CMD_RST = 7'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [7:0] LOCK_RST = 8'hFF;
  localparam logic [15:0] FBUF_ERASED = 16'hFFFF;
  localparam logic [7:0] EBUF_ERASED = 8'hFF;
  localparam logic [15:0] BOOT_START_DEF = 16'hE000;
  localparam logic [15:0] CRC_STEP = 16'h0002;
  // ==========
  // Commands
  localparam logic [6:0] CMD_NOP = 7'h00;
  localparam logic [6:0] CMD_RD_USIG = 7'h01;
  localparam logic [6:0] CMD_RD_CAL = 7'h02;
  localparam logic [6:0] CMD_WR_LOCK = 7'h08;
  localparam logic [6:0] CMD_ER_USIG = 7'h18;
  localparam logic [6:0] CMD_WR_USIG = 7'h1A;
  localparam logic [6:0] CMD_ER_APP = 7'h20;
  localparam logic [6:0] CMD_ER_APG = 7'h22;
  localparam logic [6:0] CMD_LD_FBUF = 7'h23;
  localparam logic [6:0] CMD_WR_APG = 7'h24;
  localparam logic [6:0] CMD_EW_APG = 7'h25;
  localparam logic [6:0] CMD_ER_FBUF = 7'h26;
  localparam logic [6:0] CMD_ER_BPG = 7'h2A;
  localparam logic [6:0] CMD_ER_FPG = 7'h2B;
  localparam logic [6:0] CMD_WR_BPG = 7'h2C;
  localparam logic [6:0] CMD_EW_BPG = 7'h2D;
  localparam logic [6:0] CMD_WR_FPG = 7'h2E;
  localparam logic [6:0] CMD_EW_FPG = 7'h2F;
  localparam logic [6:0] CMD_ER_EPG = 7'h32;
  localparam logic [6:0] CMD_LD_EBUF = 7'h33;
  localparam logic [6:0] CMD_WR_EPG = 7'h34;
  localparam logic [6:0] CMD_EW_EPG = 7'h35;
  localparam logic [6:0] CMD_ER_EBUF = 7'h36;
  localparam logic [6:0] CMD_APP_CRC = 7'h38;
  localparam logic [6:0] CMD_BOOT_CRC = 7'h39;
  localparam logic [6:0] CMD_RANGE_CRC = 7'h3A;
  // ==========
  // Running operation as seen by the memory macro
  typedef struct packed {
    logic active;
    logic [6:0] cmd;
    logic [PTR_W-1:0] addr;
  } nps_op_t;
endpackage

// file: nps_sync.sv
// Two-stage synchroniser for pin-level inputs
module nps_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else if (clkEn) begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end
  assign dout = sync_r;
endmodule

// file: nps_page_buf.sv
// Flash word and EEPROM byte page buffers, EEPROM bytes with load tags
module nps_page_buf #(
  parameter int FWORDS = 64,
  parameter int EBYTES = 32
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic fErase,
  input wire logic fLoad,
  input wire logic [$clog2(FWORDS)-1:0] fIdx,
  input wire logic [15:0] fData,
  input wire logic [$clog2(FWORDS)-1:0] fRdIdx,
  output logic [15:0] fRdWord,
  input wire logic eErase,
  input wire logic eLoad,
  input wire logic [$clog2(EBYTES)-1:0] eIdx,
  input wire logic [7:0] eData,
  input wire logic [$clog2(EBYTES)-1:0] eRdIdx,
  output logic [7:0] eRdByte,
  output logic [EBYTES-1:0] eTags
);
  logic [15:0] fMem_r [FWORDS];
  logic [15:0] fMem_nxt [FWORDS];
  logic [7:0] eMem_r [EBYTES];
  logic [7:0] eMem_nxt [EBYTES];
  logic [EBYTES-1:0] eTag_r;
  logic [EBYTES-1:0] eTag_nxt;
  // ==========
  // Erase fills with ones, a load ANDs into the old content
  always_comb begin
    fMem_nxt = fMem_r;
    eMem_nxt = eMem_r;
    eTag_nxt = eTag_r;
    if (fErase) begin
      fMem_nxt = '{default: nps_pkg::FBUF_ERASED};
    end else if (fLoad) begin
      fMem_nxt[fIdx] = fMem_r[fIdx] & fData;
    end
    if (eErase) begin
      eMem_nxt = '{default: nps_pkg::EBUF_ERASED};
      eTag_nxt = '0;
    end else if (eLoad) begin
      eMem_nxt[eIdx] = eMem_r[eIdx] & eData;
      eTag_nxt[eIdx] = 1'b1;
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fMem_r <= '{default: nps_pkg::FBUF_ERASED};
      eMem_r <= '{default: nps_pkg::EBUF_ERASED};
      eTag_r <= '0;
    end else if (clkEn) begin
      fMem_r <= fMem_nxt;
      eMem_r <= eMem_nxt;
      eTag_r <= eTag_nxt;
    end
  end
  assign fRdWord = fMem_r[fRdIdx];
  assign eRdByte = eMem_r[eRdIdx];
  assign eTags = eTag_r;
endmodule

// file: nps_sequencer.sv
// Page program sequencer: command triggers, access, halting, aborts
// Operation
// - Buffer-erase-write, buffer-atomic, or erase-buffer-write orders all work.
// - Tagged EEPROM bytes are erased before they are written.
// - Power-on-level supply detector on during every flash programming.
// - Brown-out monitor on during chip erase or debug link enabled.
// - Supply trip aborts the running operation at once.
// - Flash range checksum always reads whole words, an even byte count.
// - Application page operation keeps boot area readable, CPU running.
// - Boot page operation halts the CPU throughout.
// - User signature erase or write halts CPU, nothing readable.
// - Pointer splits into word field and page field.
// - Pointer bit 0 selects low or high byte on reads.
// - Target address captured at start; pointer free afterwards.
// - Action commands start on writing the execute bit.
// - Load instruction starts reads, store instruction starts writes.
// - Guarded triggers need unlock, except from the external programmer.
// - Boot code writes flash, signature, EEPROM; locks only tighter.
// - Application code reads flash only, still writes EEPROM.
// - Boot code may program any flash page, boot area too.
// - Busy flag set; control registers refuse writes while busy.
// - Unloaded flash buffer words read and program as all ones.
// - EEPROM buffer bytes tagged on load; only tagged bytes change.
module nps_sequencer #(
  parameter int PW = nps_pkg::PTR_W,
  parameter int WORD_TOP = 6,
  parameter int PAGE_TOP = 15,
  parameter int EE_BYTES = 32,
  parameter logic [15:0] BOOT_START = nps_pkg::BOOT_START_DEF
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic extProgSel,
  input wire logic guardUnlock,
  input wire logic execFromBoot,
  input wire logic loadTrig,
  input wire logic storeTrig,
  input wire logic [PW-1:0] cpuPtr,
  input wire logic [15:0] storeData,
  input wire logic [15:0] flashRdWord,
  output logic [7:0] cpuLoadByte,
  input wire logic debugLinkPin,
  input wire logic chipErasePin,
  input wire logic porTripPin,
  input wire logic bodTripPin,
  output logic porDetEn,
  output logic bodEn,
  output logic busy,
  output logic cpuHalt,
  output logic bootReadable,
  output logic appReadable,
  output nps_pkg::nps_op_t nvmOp,
  output logic [PAGE_TOP-WORD_TOP-1:0] opPage,
  output logic [WORD_TOP-1:0] opWord,
  input wire logic nvmDone,
  output logic nvmAbort,
  input wire logic [WORD_TOP-1:0] bufIdx,
  output logic [15:0] bufWord,
  input wire logic [$clog2(EE_BYTES)-1:0] eeIdx,
  output logic [7:0] eeByte,
  output logic [EE_BYTES-1:0] eeTags,
  output logic crcRead,
  output logic [PW-1:0] crcAddr
);
  localparam int EW = $clog2(EE_BYTES);
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_CRC} nps_state_t;

  // ==========
  // Decoding helpers
  function automatic logic [WORD_TOP-1:0] wordOf(input logic [PW-1:0] p);
    return p[WORD_TOP:1];
  endfunction
  function automatic logic [PAGE_TOP-WORD_TOP-1:0] pageOf(input logic [PW-1:0] p);
    return p[PAGE_TOP:WORD_TOP+1];
  endfunction
  function automatic logic isStoreOp(input logic [6:0] c);
    return c inside {nps_pkg::CMD_ER_USIG, nps_pkg::CMD_WR_USIG,
      nps_pkg::CMD_ER_APP, nps_pkg::CMD_ER_APG, nps_pkg::CMD_WR_APG,
      nps_pkg::CMD_EW_APG, nps_pkg::CMD_ER_BPG, nps_pkg::CMD_WR_BPG,
      nps_pkg::CMD_EW_BPG, nps_pkg::CMD_ER_FPG, nps_pkg::CMD_WR_FPG,
      nps_pkg::CMD_EW_FPG};
  endfunction
  function automatic logic haltsCpu(input logic [6:0] c, input logic [PW-1:0] a);
    if (c inside {nps_pkg::CMD_ER_FPG, nps_pkg::CMD_WR_FPG, nps_pkg::CMD_EW_FPG}) begin
      return a >= BOOT_START;
    end
    return c inside {nps_pkg::CMD_ER_USIG, nps_pkg::CMD_WR_USIG,
      nps_pkg::CMD_ER_APP, nps_pkg::CMD_ER_BPG, nps_pkg::CMD_WR_BPG,
      nps_pkg::CMD_EW_BPG, nps_pkg::CMD_APP_CRC, nps_pkg::CMD_BOOT_CRC,
      nps_pkg::CMD_RANGE_CRC};
  endfunction

  // ==========
  // Pin synchronisers
  logic [3:0] pinsS;
  logic debugLinkS;
  logic chipEraseS;
  logic porTripS;
  logic bodTripS;
  nps_sync #(.W(4)) uSync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clkEn(clkEn),
    .din({debugLinkPin, chipErasePin, porTripPin, bodTripPin}),
    .dout(pinsS)
  );
  assign {debugLinkS, chipEraseS, porTripS, bodTripS} = pinsS;

  // ==========
  // State declarations
  nps_state_t state_r, state_nxt;
  logic dpWrite_r, dpWrite_nxt;
  logic [7:0] dpAddr_r, dpAddr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic [6:0] cmd_r, cmd_nxt;
  logic [PW-1:0] addr_r, addr_nxt;
  logic [PW-1:0] data_r, data_nxt;
  logic abortFlag_r, abortFlag_nxt;
  logic denyFlag_r, denyFlag_nxt;
  logic [6:0] opCmd_r, opCmd_nxt;
  logic [PW-1:0] opPtr_r, opPtr_nxt;
  logic [PW-1:0] crcPtr_r, crcPtr_nxt;
  logic [PW-1:0] crcEnd_r, crcEnd_nxt;
  logic [7:0] lock_r, lock_nxt;
  logic [7:0] loadByte_r, loadByte_nxt;
  logic abort_r, abort_nxt;
  logic addrPhase, execWrite, privileged, guardOk;
  logic actGo, storeGo, loadGo, readOk, supplyTrip;
  logic fErase, fLoad, eErase, eLoad, abortEv, denyEv;
  logic [7:0] expByte;

  // ==========
  // Bus slave and register bank
  assign addrPhase = hsel && hready && htrans[1];
  assign execWrite = dpWrite_r && !busy && dpAddr_r == nps_pkg::OFS_CONTROLLER_CONTROL_A
    && hwdata[nps_pkg::EXEC_BIT];
  always_comb begin
    dpWrite_nxt = addrPhase && hwrite;
    dpAddr_nxt = addrPhase ? haddr[7:0] : dpAddr_r;
    hrdata_nxt = hrdata_r;
    cmd_nxt = cmd_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    abortFlag_nxt = abortFlag_r;
    denyFlag_nxt = denyFlag_r;
    if (addrPhase && !hwrite) begin
      case (haddr[7:0])
        nps_pkg::OFS_CMD: hrdata_nxt = 32'(cmd_r);
        nps_pkg::OFS_ADDR: hrdata_nxt = 32'(addr_r);
        nps_pkg::OFS_DATA: hrdata_nxt = 32'(data_r);
        nps_pkg::OFS_STAT: hrdata_nxt = 32'({denyFlag_r, abortFlag_r, busy});
        nps_pkg::OFS_LOCK: hrdata_nxt = 32'(lock_r);
        default: hrdata_nxt = '0;
      endcase
    end
    if (dpWrite_r && !busy) begin
      case (dpAddr_r)
        nps_pkg::OFS_CMD: cmd_nxt = hwdata[6:0];
        nps_pkg::OFS_ADDR: addr_nxt = hwdata[PW-1:0];
        nps_pkg::OFS_DATA: data_nxt = hwdata[PW-1:0];
        default: ;
      endcase
    end
    if (dpWrite_r && dpAddr_r == nps_pkg::OFS_STAT) begin
      abortFlag_nxt = abortFlag_r && !hwdata[nps_pkg::ABORT_BIT];
      denyFlag_nxt = denyFlag_r && !hwdata[nps_pkg::DENY_BIT];
    end
    abortFlag_nxt = abortFlag_nxt || abortEv;
    denyFlag_nxt = denyFlag_nxt || denyEv;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dpWrite_r <= 1'b0;
      dpAddr_r <= '0;
      hrdata_r <= '0;
      cmd_r <= nps_pkg::CMD_RST;
      addr_r <= nps_pkg::PTR_RST;
      data_r <= nps_pkg::PTR_RST;
      abortFlag_r <= 1'b0;
      denyFlag_r <= 1'b0;
    end else if (clkEn) begin
      dpWrite_r <= dpWrite_nxt;
      dpAddr_r <= dpAddr_nxt;
      hrdata_r <= hrdata_nxt;
      cmd_r <= cmd_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      abortFlag_r <= abortFlag_nxt;
      denyFlag_r <= denyFlag_nxt;
    end
  end
  assign hrdata = hrdata_r;
  assign hreadyout = clkEn;
  assign hresp = 1'b0;

  // ==========
  // Trigger qualification
  assign busy = state_r != ST_IDLE;
  assign privileged = execFromBoot || extProgSel;
  assign guardOk = guardUnlock || extProgSel;
  assign actGo = execWrite && guardOk;
  assign storeGo = storeTrig && !busy;
  assign readOk = !busy || (bootReadable && cpuPtr >= BOOT_START);
  assign loadGo = loadTrig && readOk && cmd_r inside {nps_pkg::CMD_NOP,
    nps_pkg::CMD_RD_USIG, nps_pkg::CMD_RD_CAL};
  assign porDetEn = busy && isStoreOp(opCmd_r);
  assign bodEn = chipEraseS || debugLinkS;
  assign supplyTrip = (porDetEn && porTripS) || (bodEn && bodTripS);
  assign expByte = cpuPtr[0] ? flashRdWord[15:8] : flashRdWord[7:0];

  // ==========
  // Sequencer
  always_comb begin
    state_nxt = state_r;
    opCmd_nxt = opCmd_r;
    opPtr_nxt = opPtr_r;
    crcPtr_nxt = crcPtr_r;
    crcEnd_nxt = crcEnd_r;
    lock_nxt = lock_r;
    loadByte_nxt = loadByte_r;
    abort_nxt = 1'b0;
    abortEv = 1'b0;
    denyEv = 1'b0;
    fErase = 1'b0;
    fLoad = 1'b0;
    eErase = 1'b0;
    eLoad = 1'b0;
    if (loadGo) begin
      loadByte_nxt = expByte;
    end
    case (state_r)
      ST_IDLE: begin
        if (actGo) begin
          opCmd_nxt = cmd_r;
          case (cmd_r)
            nps_pkg::CMD_ER_FBUF: fErase = 1'b1;
            nps_pkg::CMD_ER_EBUF: eErase = 1'b1;
            nps_pkg::CMD_WR_LOCK: begin
              if (privileged) begin
                lock_nxt = lock_r & data_r[7:0];
                eErase = 1'b1;
              end else begin
                denyEv = 1'b1;
              end
            end
            nps_pkg::CMD_RANGE_CRC: begin
              crcPtr_nxt = {addr_r[PW-1:1], 1'b0};
              crcEnd_nxt = data_r;
              state_nxt = ST_CRC;
            end
            nps_pkg::CMD_APP_CRC: begin
              crcPtr_nxt = '0;
              crcEnd_nxt = BOOT_START - PW'(1);
              state_nxt = ST_CRC;
            end
            nps_pkg::CMD_BOOT_CRC: begin
              crcPtr_nxt = BOOT_START;
              crcEnd_nxt = '1;
              state_nxt = ST_CRC;
            end
            nps_pkg::CMD_ER_EPG, nps_pkg::CMD_WR_EPG, nps_pkg::CMD_EW_EPG: begin
              opPtr_nxt = addr_r;
              state_nxt = ST_RUN;
            end
            default: ;
          endcase
        end else if (storeGo) begin
          if (cmd_r == nps_pkg::CMD_LD_FBUF) begin
            fLoad = 1'b1;
          end else if (cmd_r == nps_pkg::CMD_LD_EBUF) begin
            eLoad = 1'b1;
          end else if (isStoreOp(cmd_r) && guardOk) begin
            if (privileged) begin
              opCmd_nxt = cmd_r;
              opPtr_nxt = cpuPtr;
              state_nxt = ST_RUN;
            end else begin
              denyEv = 1'b1;
            end
          end
        end
      end
      ST_RUN: begin
        if (supplyTrip) begin
          abort_nxt = 1'b1;
          abortEv = 1'b1;
          state_nxt = ST_IDLE;
        end else if (nvmDone) begin
          fErase = opCmd_r inside {nps_pkg::CMD_WR_FPG, nps_pkg::CMD_EW_FPG,
            nps_pkg::CMD_WR_APG, nps_pkg::CMD_EW_APG, nps_pkg::CMD_WR_BPG,
            nps_pkg::CMD_EW_BPG, nps_pkg::CMD_WR_USIG};
          eErase = opCmd_r inside {nps_pkg::CMD_WR_EPG, nps_pkg::CMD_EW_EPG};
          state_nxt = ST_IDLE;
        end
      end
      ST_CRC: begin
        if (supplyTrip) begin
          abort_nxt = 1'b1;
          abortEv = 1'b1;
          state_nxt = ST_IDLE;
        end else begin
          crcPtr_nxt = crcPtr_r + nps_pkg::CRC_STEP;
          if (crcPtr_r[PW-1:1] == crcEnd_r[PW-1:1]) begin
            state_nxt = ST_IDLE;
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      opCmd_r <= nps_pkg::CMD_RST;
      opPtr_r <= nps_pkg::PTR_RST;
      crcPtr_r <= nps_pkg::PTR_RST;
      crcEnd_r <= nps_pkg::PTR_RST;
      lock_r <= nps_pkg::LOCK_RST;
      loadByte_r <= '0;
      abort_r <= 1'b0;
    end else if (clkEn) begin
      state_r <= state_nxt;
      opCmd_r <= opCmd_nxt;
      opPtr_r <= opPtr_nxt;
      crcPtr_r <= crcPtr_nxt;
      crcEnd_r <= crcEnd_nxt;
      lock_r <= lock_nxt;
      loadByte_r <= loadByte_nxt;
      abort_r <= abort_nxt;
    end
  end

  // ==========
  // Outputs
  assign cpuHalt = busy && haltsCpu(opCmd_r, opPtr_r);
  assign bootReadable = !cpuHalt;
  assign appReadable = !busy;
  assign nvmOp = '{active: state_r == ST_RUN, cmd: opCmd_r, addr: opPtr_r};
  assign opPage = pageOf(opPtr_r);
  assign opWord = wordOf(opPtr_r);
  assign nvmAbort = abort_r;
  assign cpuLoadByte = loadByte_r;
  assign crcRead = state_r == ST_CRC;
  assign crcAddr = crcPtr_r;

  // ==========
  // Page buffers
  nps_page_buf #(.FWORDS(2 ** WORD_TOP), .EBYTES(EE_BYTES)) uBuf (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clkEn(clkEn),
    .fErase(fErase),
    .fLoad(fLoad),
    .fIdx(wordOf(cpuPtr)),
    .fData(storeData),
    .fRdIdx(bufIdx),
    .fRdWord(bufWord),
    .eErase(eErase),
    .eLoad(eLoad),
    .eIdx(cpuPtr[EW-1:0]),
    .eData(storeData[7:0]),
    .eRdIdx(eeIdx),
    .eRdByte(eeByte),
    .eTags(eeTags)
  );

  // ==========
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_trip;
    busy && supplyTrip && clkEn;
  endsequence
  sequence s_aborted;
    nvmAbort && !busy && abortFlag_r;
  endsequence
  a_supply_abort: assert property (s_trip |=> s_aborted)
    else $error("supply trip did not abort");
  a_busy_blocks: assert property (busy && dpWrite_r && dpAddr_r == nps_pkg::OFS_CMD
    |=> $stable(cmd_r))
    else $error("command changed while busy");
  a_no_queue: assert property (busy && storeTrig && clkEn |=> $stable(opPtr_r))
    else $error("trigger taken while busy");
  a_addr_held: assert property (state_r == ST_RUN && $past(state_r) == ST_RUN
    |-> $stable(opPtr_r))
    else $error("latched address moved");
  a_boot_halt: assert property (state_r == ST_RUN && opCmd_r == nps_pkg::CMD_WR_BPG
    |-> cpuHalt && !bootReadable)
    else $error("boot page write without halt");
  a_app_runs: assert property (state_r == ST_RUN && opCmd_r == nps_pkg::CMD_WR_APG
    |-> !cpuHalt && bootReadable && !appReadable)
    else $error("application page write halted CPU");
  a_usig_halt: assert property (state_r == ST_RUN && opCmd_r == nps_pkg::CMD_WR_USIG
    |-> cpuHalt && !bootReadable && !appReadable)
    else $error("signature write without halt");
  a_por_on: assert property (state_r == ST_RUN && isStoreOp(opCmd_r) |-> porDetEn)
    else $error("detector off during programming");
  a_bod_on: assert property (debugLinkS || chipEraseS |-> bodEn)
    else $error("brown-out monitor off");
  a_crc_even: assert property (crcRead && clkEn && !supplyTrip
    |=> !crcAddr[0] && (crcRead || $past(crcAddr[PW-1:1]) == crcEnd_r[PW-1:1]))
    else $error("checksum read not word aligned");
  a_byte_pick: assert property (loadGo && clkEn |=> cpuLoadByte == $past(expByte))
    else $error("wrong byte returned");
endmodule

// file: nps_mem_model.sv
// Memory macro model that finishes page operations
module nps_mem_model (
  input wire logic ref_clk,
  input wire logic [15:0] ptr,
  input wire nps_pkg::nps_op_t op,
  input wire logic [3:0] delay,
  output logic [15:0] rdWord,
  output logic done
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  // Word stored at the pointer, a fixed scramble of the address
  assign rdWord = ptr ^ 16'hA5C3;
  // Ends a running operation after a chosen delay; an abort clears the count to zero
  always @(posedge ref_clk) begin
    cnt <= op.active ? cnt + 1 : 0;
    done <= op.active && (cnt == int'(delay));
  end
endmodule

// file: tb_top.sv
// Self-checking bench of the page program sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, nrst = 0, hsel = 0, hwrite = 0, loadTrig = 0, storeTrig = 0;
  logic guardUnlock = 0, execFromBoot = 1, extProgSel = 0;
  logic debugLinkPin = 0, chipErasePin = 0, porTripPin = 0, bodTripPin = 0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd, eeTags;
  logic [15:0] cpuPtr = 16'h0000, storeData = 16'h0000, flashRdWord, bufWord, p, crcAddr;
  logic [5:0] bufIdx = 6'h00, opWord;
  logic [8:0] opPage;
  logic [7:0] cpuLoadByte, eeByte;
  logic [3:0] mDelay = 4'h2;
  logic [3:0] hHalt = 4'b0111;
  logic [31:0] seed = 32'h0000_198E;
  logic hreadyout, hresp, busy, cpuHalt, bootReadable, appReadable, porDetEn, bodEn;
  logic nvmDone, nvmAbort, crcRead;
  nps_pkg::nps_op_t nvmOp;
  int failCount = 0, checkCount = 0, cyc = 0, crcCnt = 0, abortCnt = 0, oddCnt = 0;
  logic [6:0] hCmd [4] = '{nps_pkg::CMD_WR_BPG, nps_pkg::CMD_EW_FPG, nps_pkg::CMD_WR_USIG,
    nps_pkg::CMD_EW_FPG};
  logic [15:0] hAdr [4] = '{16'hE100, 16'hF000, 16'h0000, 16'h1000};

  nps_sequencer i_dut (.ref_clk, .nrst, .clkEn(1'b1), .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .extProgSel,
    .guardUnlock, .execFromBoot, .loadTrig, .storeTrig, .cpuPtr, .storeData, .flashRdWord,
    .cpuLoadByte, .debugLinkPin, .chipErasePin, .porTripPin, .bodTripPin, .porDetEn, .bodEn,
    .busy, .cpuHalt, .bootReadable, .appReadable, .nvmOp, .opPage, .opWord, .nvmDone,
    .nvmAbort, .bufIdx, .bufWord, .eeIdx(5'h05), .eeByte, .eeTags, .crcRead, .crcAddr);
  nps_mem_model i_mem (.ref_clk, .ptr(cpuPtr), .op(nvmOp), .delay(mDelay),
    .rdWord(flashRdWord), .done(nvmDone));

  // ==========
  // Clock, watchdog and monitors
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (crcRead) crcCnt++;
    if (crcRead && crcAddr[0]) oddCnt++;
    if (nvmAbort) abortCnt++;
    if (cyc == 3000) begin
      failCount++;
      finishTest();
    end
  end

  // ==========
  // Helpers
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] pick(input logic [15:0] w, input logic b);
    return b ? w[15:8] : w[7:0];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      failCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    rd = hrdata;
  endtask
  task automatic cmd(input logic [6:0] c);
    bus(1'b1, nps_pkg::OFS_CMD, {25'h000_0000, c});
  endtask
  task automatic store(input logic [15:0] a, input logic [15:0] d);
    cpuPtr <= a;
    storeData <= d;
    storeTrig <= 1'b1;
    @(posedge ref_clk);
    storeTrig <= 1'b0;
    #1;
  endtask
  task automatic idle();
    #1;
    while (busy !== 1'b0) @(posedge ref_clk);
    @(posedge ref_clk);
  endtask
  task automatic finishTest();
    $display("checks=%0d mismatches=%0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========
  // Scenarios
  initial begin
    logic [15:0] e;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    bus(1'b0, nps_pkg::OFS_LOCK, 32'h0000_0000);
    chk(rd, 32'h0000_00FF);
    bus(1'b0, 8'h40, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk({hresp, busy, cpuHalt, bootReadable, appReadable, bodEn}, 32'h0000_0006);
    $display("reset test done");
    repeat (4) begin
      p = 16'(rnd());
      cpuPtr <= p;
      loadTrig <= 1'b1;
      @(posedge ref_clk);
      loadTrig <= 1'b0;
      @(posedge ref_clk);
      #1;
      chk(cpuLoadByte, pick(p ^ 16'hA5C3, p[0]));
    end
    $display("byte read test done");
    cmd(nps_pkg::CMD_LD_FBUF);
    p = 16'(rnd()) & 16'h7FFF;
    e = 16'(rnd());
    store(p, e);
    bufIdx <= p[6:1];
    #1;
    chk(bufWord, e);
    bufIdx <= p[6:1] + 6'h01;
    #1;
    chk(bufWord, 16'hFFFF);
    guardUnlock <= 1'b1;
    cmd(nps_pkg::CMD_ER_APG);
    store(p, 16'h0000);
    idle();
    mDelay <= 4'hC;
    cmd(nps_pkg::CMD_WR_APG);
    store(p, 16'h0000);
    chk({busy, cpuHalt, bootReadable, porDetEn}, 32'h0000_000B);
    store(~p, 16'h0000);
    bus(1'b1, nps_pkg::OFS_ADDR, 32'h0000_1234);
    bus(1'b1, nps_pkg::OFS_CMD, 32'h0000_0000);
    bus(1'b0, nps_pkg::OFS_ADDR, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk({opPage, opWord}, {p[15:7], p[6:1]});
    chk(nvmOp.addr, p);
    bufIdx <= p[6:1];
    idle();
    chk(bufWord, 16'hFFFF);
    $display("app page test done");
    for (int i = 0; i < 4; i++) begin
      mDelay <= 4'(rnd());
      cmd(hCmd[i]);
      store(hAdr[i], 16'h0000);
      chk({cpuHalt, bootReadable, busy}, {hHalt[i], !hHalt[i], 1'b1});
      idle();
    end
    guardUnlock <= 1'b0;
    cmd(nps_pkg::CMD_WR_FPG);
    for (int i = 0; i < 2; i++) begin
      extProgSel <= i[0];
      store(16'h2000, 16'h0000);
      chk(busy, i[0]);
      idle();
    end
    extProgSel <= 1'b0;
    guardUnlock <= 1'b1;
    execFromBoot <= 1'b0;
    cmd(nps_pkg::CMD_WR_APG);
    store(16'h2000, 16'h0000);
    chk(busy, 1'b0);
    bus(1'b0, nps_pkg::OFS_STAT, 32'h0000_0000);
    chk(rd[2:0], 3'h4);
    cmd(nps_pkg::CMD_LD_EBUF);
    store(16'h0005, 16'h00AB);
    chk(eeTags, 32'h0000_0020);
    chk(eeByte, 8'hAB);
    execFromBoot <= 1'b1;
    cmd(nps_pkg::CMD_EW_EPG);
    bus(1'b1, nps_pkg::OFS_CONTROLLER_CONTROL_A, 32'h0000_0001);
    idle();
    chk(eeTags, 32'h0000_0000);
    $display("access test done");
    mDelay <= 4'hF;
    cmd(nps_pkg::CMD_EW_FPG);
    store(16'h3000, 16'h0000);
    porTripPin <= 1'b1;
    repeat (5) @(posedge ref_clk);
    #1;
    chk({busy, nvmOp.active}, 2'b00);
    chk(abortCnt, 1);
    porTripPin <= 1'b0;
    bus(1'b0, nps_pkg::OFS_STAT, 32'h0000_0000);
    chk(rd[1], 1'b1);
    p = (16'(rnd()) & 16'h7FFF) | 16'h0001;
    e = p + 16'(rnd() & 32'h0000_003F);
    cmd(nps_pkg::CMD_RANGE_CRC);
    bus(1'b1, nps_pkg::OFS_ADDR, {16'h0000, p});
    bus(1'b1, nps_pkg::OFS_DATA, {16'h0000, e});
    crcCnt = 0;
    bus(1'b1, nps_pkg::OFS_CONTROLLER_CONTROL_A, 32'h0000_0001);
    idle();
    chk(crcCnt, (e >> 1) - (p >> 1) + 16'h0001);
    chk(oddCnt, 0);
    for (int i = 0; i < 2; i++) begin
      {debugLinkPin, chipErasePin} <= 2'(i + 1);
      repeat (4) @(posedge ref_clk);
      #1;
      chk(bodEn, 1'b1);
      {debugLinkPin, chipErasePin} <= 2'b00;
      repeat (4) @(posedge ref_clk);
      #1;
      chk(bodEn, 1'b0);
    end
    debugLinkPin <= 1'b1;
    cmd(nps_pkg::CMD_APP_CRC);
    bus(1'b1, nps_pkg::OFS_CONTROLLER_CONTROL_A, 32'h0000_0001);
    bodTripPin <= 1'b1;
    idle();
    chk(abortCnt, 2);
    $display("supply and checksum test done");
    finishTest();
  end
endmodule
